/* File: core/atc_params.svh */
`ifndef ATC_PARAMS_SVH
`define ATC_PARAMS_SVH

// Register byte offsets on the module's 16-bit register port
`define ATC_OFS_LVL1    6'h28
`define ATC_OFS_LVL2    6'h2a
`define ATC_OFS_LVL3    6'h2c
`define ATC_OFS_LVL4    6'h2e
`define ATC_OFS_PER_HI  6'h30
`define ATC_OFS_PER_LO  6'h32
`define ATC_OFS_PRE_HI  6'h34
`define ATC_OFS_PRE_LO  6'h36
`define ATC_OFS_CNT_HI  6'h38
`define ATC_OFS_CNT_LO  6'h3a
`define ATC_OFS_TRIG    6'h3c

// Reset values
`define ATC_RST_WORD    16'h0000
`define ATC_RST_BYTE    8'h00
`define ATC_RST_HI6     6'h00

// Field widths of the split registers
`define ATC_PER_HI_W    8
`define ATC_CNT_HI_W    6
`define ATC_LO_W        16

// Clock and internal timebase rates in Hz
`define ATC_CLK_HZ      20000000
`define ATC_TB_HZ       10000000
`define ATC_TB_DIV      (`ATC_CLK_HZ / `ATC_TB_HZ)

`endif

/* File: core/atc_pkg.sv */
package atc_pkg;

    typedef enum logic [2:0] {
        atc_idle,
        atc_pre,
        atc_wait,
        atc_post,
        atc_done
    } atc_state_t;

    // Trigger source/control word, bit 15 first
    typedef struct packed {
        logic [3:0] level_compare_enables;
        logic [1:0] pairing_line_select;
        logic       external_pin_trigger_enable;
        logic       edge_select;
        logic       soft_trigger;
        logic       leader;
        logic       follower;
        logic       line_enable;
        logic       line_drive;
        logic [2:0] line_select;
    } atc_trig_ctl_t;

    // Per-channel level word
    typedef struct packed {
        logic [7:0] level_value;
        logic [6:0] zero;
        logic       compare_sense;
    } atc_level_t;

    typedef struct packed {
        logic sample_strobe;
        logic acquiring;
        logic triggered;
        logic done;
    } atc_status_t;

endpackage

/* File: core/atc_top.sv */
`timescale 1ns/10ps
`include "atc_params.svh"
module atc_top
    import atc_pkg::*;
#(
    parameter int CHANNELS = 4,
    parameter int LEVEL_W  = 8,
    parameter int COUNT_W  = 22,
    parameter int PERIOD_W = 24
) (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic [5:0]              reg_addr,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    input  wire logic [15:0]             reg_wdata,
    output logic      [15:0]             reg_rdata,
    input  wire logic                    acq_start,
    input  wire logic                    acq_abort,
    input  wire logic                    mem_full,
    input  wire logic                    ext_tb_sel,
    input  wire logic                    ext_tb_tick,
    input  wire logic                    ext_trig_pin,
    input  wire logic [7:0]              bp_trig_in,
    output logic      [7:0]              bp_trig_out,
    output logic      [7:0]              bp_trig_oe,
    input  wire logic                    rd_valid,
    input  wire logic [CHANNELS-1:0][LEVEL_W-1:0] rd_data,
    output logic      [CHANNELS-1:0]     level_trigger_per_channel,
    output atc_status_t                  status
);
    localparam int TB_DIV = `ATC_TB_DIV;
    localparam int DIV_W  = (TB_DIV > 1) ? $clog2(TB_DIV) : 1;
    ////////////////////////////////////////////////////////////////////////////
    // Register file
    atc_level_t    level_reg [CHANNELS];
    atc_level_t    level_next [CHANNELS];
    logic [7:0]    per_hi_reg,  per_hi_next;
    logic [15:0]   per_lo_reg,  per_lo_next;
    logic [5:0]    pre_hi_reg,  pre_hi_next;
    logic [15:0]   pre_lo_reg,  pre_lo_next;
    logic [5:0]    cnt_hi_reg,  cnt_hi_next;
    logic [15:0]   cnt_lo_reg,  cnt_lo_next;
    atc_trig_ctl_t trig_reg,    trig_next;
    logic [15:0]   rdata_reg,   rdata_next;
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            level_next[i] = level_reg[i];
        end
        per_hi_next = per_hi_reg;
        per_lo_next = per_lo_reg;
        pre_hi_next = pre_hi_reg;
        pre_lo_next = pre_lo_reg;
        cnt_hi_next = cnt_hi_reg;
        cnt_lo_next = cnt_lo_reg;
        trig_next   = trig_reg;
        if (reg_wr) begin
            unique case (reg_addr)
                `ATC_OFS_LVL1,
                `ATC_OFS_LVL2,
                `ATC_OFS_LVL3,
                `ATC_OFS_LVL4: begin
                    for (int i = 0; i < CHANNELS; i++) begin
                        if (reg_addr == `ATC_OFS_LVL1 + 6'(2 * i)) begin
                            level_next[i].level_value   = reg_wdata[15:8];
                            level_next[i].compare_sense = reg_wdata[0];
                        end
                    end
                end
                `ATC_OFS_PER_HI: per_hi_next = reg_wdata[`ATC_PER_HI_W-1:0];
                `ATC_OFS_PER_LO: per_lo_next = reg_wdata;
                `ATC_OFS_PRE_HI: pre_hi_next = reg_wdata[`ATC_CNT_HI_W-1:0];
                `ATC_OFS_PRE_LO: pre_lo_next = reg_wdata;
                `ATC_OFS_CNT_HI: cnt_hi_next = reg_wdata[`ATC_CNT_HI_W-1:0];
                `ATC_OFS_CNT_LO: cnt_lo_next = reg_wdata;
                `ATC_OFS_TRIG:   trig_next   = atc_trig_ctl_t'(reg_wdata);
                default: ;
            endcase
        end
    end
    // Read data is registered; unmapped offsets read zero
    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd) begin
            rdata_next = `ATC_RST_WORD;
            for (int i = 0; i < CHANNELS; i++) begin
                if (reg_addr == `ATC_OFS_LVL1 + 6'(2 * i)) begin
                    rdata_next = {level_reg[i].level_value, 7'h00,
                                  level_reg[i].compare_sense};
                end
            end
            unique case (reg_addr)
                `ATC_OFS_PER_HI: rdata_next = {8'h00, per_hi_reg};
                `ATC_OFS_PER_LO: rdata_next = per_lo_reg;
                `ATC_OFS_PRE_HI: rdata_next = {10'h000, pre_hi_reg};
                `ATC_OFS_PRE_LO: rdata_next = pre_lo_reg;
                `ATC_OFS_CNT_HI: rdata_next = {10'h000, cnt_hi_reg};
                `ATC_OFS_CNT_LO: rdata_next = cnt_lo_reg;
                `ATC_OFS_TRIG:   rdata_next = trig_reg;
                default: ;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < CHANNELS; i++) begin
                level_reg[i] <= atc_level_t'(`ATC_RST_WORD);
            end
            per_hi_reg <= `ATC_RST_BYTE;
            per_lo_reg <= `ATC_RST_WORD;
            pre_hi_reg <= `ATC_RST_HI6;
            pre_lo_reg <= `ATC_RST_WORD;
            cnt_hi_reg <= `ATC_RST_HI6;
            cnt_lo_reg <= `ATC_RST_WORD;
            trig_reg   <= atc_trig_ctl_t'(`ATC_RST_WORD);
            rdata_reg  <= `ATC_RST_WORD;
        end else begin
            level_reg  <= level_next;
            per_hi_reg <= per_hi_next;
            per_lo_reg <= per_lo_next;
            pre_hi_reg <= pre_hi_next;
            pre_lo_reg <= pre_lo_next;
            cnt_hi_reg <= cnt_hi_next;
            cnt_lo_reg <= cnt_lo_next;
            trig_reg   <= trig_next;
            rdata_reg  <= rdata_next;
        end
    end
    assign reg_rdata = rdata_reg;
    logic [PERIOD_W-1:0] period;
    logic [COUNT_W-1:0]  pre_target;
    logic [COUNT_W-1:0]  total_target;
    assign period       = PERIOD_W'({per_hi_reg, per_lo_reg});
    assign pre_target   = COUNT_W'({pre_hi_reg, pre_lo_reg});
    assign total_target = COUNT_W'({cnt_hi_reg, cnt_lo_reg});

    ////////////////////////////////////////////////////////////////////////////
    // Timebase and sample period
    atc_state_t          state_reg, state_next;
    logic [DIV_W-1:0]    div_reg,   div_next;
    logic [PERIOD_W-1:0] per_cnt_reg, per_cnt_next;
    logic                tb_tick;
    logic                per_hit;
    logic                running;
    assign running = (state_reg == atc_pre) || (state_reg == atc_wait)
                  || (state_reg == atc_post);
    assign tb_tick = ext_tb_sel ? ext_tb_tick : (div_reg == DIV_W'(TB_DIV - 1));
    // A period of zero is treated as one tick so sampling never stalls
    assign per_hit = running && tb_tick && (per_cnt_reg + PERIOD_W'(1) >= period);
    always_comb begin
        div_next     = (div_reg == DIV_W'(TB_DIV - 1)) ? '0 : div_reg + DIV_W'(1);
        per_cnt_next = per_cnt_reg;
        if (!running) begin
            per_cnt_next = '0;
        end else if (tb_tick) begin
            per_cnt_next = per_hit ? '0 : per_cnt_reg + PERIOD_W'(1);
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_reg     <= '0;
            per_cnt_reg <= '0;
        end else begin
            div_reg     <= div_next;
            per_cnt_reg <= per_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trigger sources
    logic [7:0]          bp_prev_reg;
    logic                ext_prev_reg;
    logic [2:0]          pair_line;
    logic                line_fire;
    logic                pair_fire;
    logic                ext_fire;
    logic                level_fire;
    logic                trig_any;
    logic [CHANNELS-1:0] hit;
    function automatic logic edge_seen(input logic cur, input logic prev, input logic rise);
        edge_seen = rise ? (cur & ~prev) : (~cur & prev);
    endfunction
    assign pair_line = {trig_reg.pairing_line_select, 1'b0};
    assign line_fire = trig_reg.line_enable && !trig_reg.line_drive
                    && edge_seen(bp_trig_in[trig_reg.line_select],
                                 bp_prev_reg[trig_reg.line_select], trig_reg.edge_select);
    assign pair_fire = trig_reg.follower
                    && edge_seen(bp_trig_in[pair_line], bp_prev_reg[pair_line],
                                 trig_reg.edge_select);
    assign ext_fire  = trig_reg.external_pin_trigger_enable
                    && edge_seen(ext_trig_pin, ext_prev_reg, trig_reg.edge_select);
    generate
        for (genvar c = 0; c < CHANNELS; c++) begin : g_cmp
            logic signed [LEVEL_W-1:0] rd_s;
            logic signed [LEVEL_W-1:0] lv_s;
            assign rd_s   = rd_data[c];
            assign lv_s   = level_reg[c].level_value;
            // Sense 0 fires above the level, 1 fires below
            assign hit[c] = rd_valid && (level_reg[c].compare_sense ?
                            (rd_s < lv_s) : (rd_s > lv_s));
        end
    endgenerate
    assign level_fire = |(hit & trig_reg.level_compare_enables);
    // Software trigger is a level: it fires as soon as the wait phase starts
    assign trig_any   = line_fire || pair_fire || ext_fire || level_fire
                     || trig_reg.soft_trigger;
    ////////////////////////////////////////////////////////////////////////////
    // Acquisition sequence
    logic [COUNT_W-1:0] pre_cnt_reg,  pre_cnt_next;
    logic [COUNT_W-1:0] post_cnt_reg, post_cnt_next;
    logic               trig_reg_q,   trig_q_next;
    logic               strobe_reg,   strobe_next;
    logic [7:0]         bp_out_reg,   bp_out_next;
    logic [7:0]         bp_oe_reg,    bp_oe_next;
    logic [CHANNELS-1:0] lvl_out_reg;
    logic               post_full;
    logic               finish;
    // Total includes pre-trigger readings; checked before the next strobe
    assign post_full = ({1'b0, post_cnt_reg} + {1'b0, pre_target})
                    >= {1'b0, total_target};
    assign finish = (total_target != '0) ? post_full : mem_full;
    always_comb begin
        state_next    = state_reg;
        pre_cnt_next  = pre_cnt_reg;
        post_cnt_next = post_cnt_reg;
        trig_q_next   = trig_reg_q;
        strobe_next   = 1'b0;
        if (acq_abort) begin
            state_next = atc_idle;
            trig_q_next = 1'b0;
        end else if (acq_start) begin
            state_next    = atc_pre;
            pre_cnt_next  = '0;
            post_cnt_next = '0;
            trig_q_next   = 1'b0;
        end else begin
            unique case (state_reg)
                atc_idle, atc_done: ;
                atc_pre: begin
                    if (pre_cnt_reg >= pre_target) begin
                        state_next = atc_wait;
                    end else if (per_hit) begin
                        strobe_next  = 1'b1;
                        pre_cnt_next = pre_cnt_reg + COUNT_W'(1);
                    end
                end
                atc_wait: begin
                    strobe_next = per_hit;
                    if (trig_any) begin
                        state_next    = atc_post;
                        post_cnt_next = '0;
                        trig_q_next   = 1'b1;
                    end
                end
                atc_post: begin
                    if (finish) begin
                        state_next = atc_done;
                    end else if (per_hit) begin
                        strobe_next   = 1'b1;
                        post_cnt_next = post_cnt_reg + COUNT_W'(1);
                    end
                end
            endcase
        end
    end
    // Drive the chosen line when set to output, and the pairing line as leader
    always_comb begin
        bp_oe_next  = 8'h00;
        bp_out_next = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if ((trig_reg.line_enable && trig_reg.line_drive
                 && trig_reg.line_select == 3'(i))
                || (trig_reg.leader && pair_line == 3'(i))) begin
                bp_oe_next[i]  = 1'b1;
                bp_out_next[i] = trig_q_next;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg    <= atc_idle;
            pre_cnt_reg  <= '0;
            post_cnt_reg <= '0;
            trig_reg_q   <= 1'b0;
            strobe_reg   <= 1'b0;
            bp_out_reg   <= 8'h00;
            bp_oe_reg    <= 8'h00;
            bp_prev_reg  <= '1;  // Pulled-up lines idle high, so no false edge
            ext_prev_reg <= 1'b0;
            lvl_out_reg  <= '0;
        end else begin
            state_reg    <= state_next;
            pre_cnt_reg  <= pre_cnt_next;
            post_cnt_reg <= post_cnt_next;
            trig_reg_q   <= trig_q_next;
            strobe_reg   <= strobe_next;
            bp_out_reg   <= bp_out_next;
            bp_oe_reg    <= bp_oe_next;
            bp_prev_reg  <= bp_trig_in;
            ext_prev_reg <= ext_trig_pin;
            lvl_out_reg  <= hit & trig_reg.level_compare_enables;
        end
    end
    assign bp_trig_out               = bp_out_reg;
    assign bp_trig_oe                = bp_oe_reg;
    assign level_trigger_per_channel = lvl_out_reg;
    assign status.sample_strobe      = strobe_reg;
    assign status.acquiring          = (state_reg != atc_idle) && (state_reg != atc_done);
    assign status.triggered          = trig_reg_q;
    assign status.done               = (state_reg == atc_done);
endmodule // atc_top

/* File: testbench/atc_peer.sv */
`timescale 1ns/10ps
module atc_peer (
    input wire logic       clk,
    input wire logic       pulse_go,
    input wire logic [2:0] pulse_line,
    input wire logic [7:0] dut_oe,
    input wire logic [7:0] dut_out,
    output logic     [7:0] line_level
);
    logic [7:0] low_reg = 8'h00;
    logic [2:0] hold_reg = 3'h0;
    // Open-collector lines with pull-ups: released reads high, any low driver wins
    assign line_level = ~low_reg & (~dut_oe | dut_out);
    always @(posedge clk) begin
        if (pulse_go) begin
            low_reg <= 8'h01 << pulse_line;
            hold_reg <= 3'h4;
        end else if (hold_reg != 3'h0) begin
            hold_reg <= hold_reg - 3'h1;
        end else begin
            low_reg <= 8'h00;
        end
    end
endmodule // atc_peer

/* File: testbench/atc_properties.sv */
`timescale 1ns/10ps
`include "atc_params.svh"
module atc_properties
    import atc_pkg::*;
#(
    parameter int CHANNELS = 4,
    parameter int LEVEL_W  = 8,
    parameter int COUNT_W  = 22,
    parameter int PERIOD_W = 24
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [5:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        acq_start,
    input wire logic        acq_abort,
    input wire logic        mem_full,
    input wire logic        ext_tb_sel,
    input wire logic        ext_tb_tick,
    input wire logic        ext_trig_pin,
    input wire logic [7:0]  bp_trig_in,
    input wire logic [7:0]  bp_trig_out,
    input wire logic [7:0]  bp_trig_oe,
    input wire logic        rd_valid,
    input wire logic [CHANNELS-1:0][LEVEL_W-1:0] rd_data,
    input wire logic [CHANNELS-1:0] level_trigger_per_channel,
    input atc_status_t      status
);
    atc_trig_ctl_t    trig_reg;
    logic [3:0][15:0] lvl_reg;
    logic [7:0]       allow_oe;
    logic [3:0]       hit_exp;
    //////////////////////////////////////////////////////////////////////////
    // Shadow copies of the control words, updated on the same edge as the design
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trig_reg <= '0;
            lvl_reg <= '0;
        end else if (reg_wr) begin
            if (reg_addr == `ATC_OFS_TRIG) trig_reg <= reg_wdata;
            if (reg_addr[5:3] == 3'h5) lvl_reg[reg_addr[2:1]] <= reg_wdata;
        end
    end
    always_comb begin
        allow_oe = 8'h00;
        if (trig_reg.line_drive && trig_reg.line_enable) allow_oe[trig_reg.line_select] = 1'b1;
        if (trig_reg.leader) allow_oe[{trig_reg.pairing_line_select, 1'b0}] = 1'b1;
        for (int c = 0; c < 4; c++) begin
            hit_exp[c] = trig_reg.level_compare_enables[c] && (lvl_reg[c][0] ?
                ($signed(rd_data[c]) < $signed(lvl_reg[c][15:8])) :
                ($signed(rd_data[c]) > $signed(lvl_reg[c][15:8])));
        end
    end
    //////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    per_hi_pad_a: assert property (reg_rd && reg_addr == `ATC_OFS_PER_HI |=>
        reg_rdata[15:8] == 8'h00) else $error("period high pad bits set");
    cnt_hi_pad_a: assert property (reg_rd && (reg_addr == `ATC_OFS_PRE_HI ||
        reg_addr == `ATC_OFS_CNT_HI) |=> reg_rdata[15:6] == 10'h000)
        else $error("count high pad bits set");
    lvl_pad_a: assert property (reg_rd && reg_addr[5:3] == 3'h5 |=>
        reg_rdata[7:1] == 7'h00) else $error("level pad bits set");
    // Config changes take a cycle or two to reach the pins, so judge only when settled
    oe_allowed_a: assert property ($stable(trig_reg) [*3] |->
        (bp_trig_oe & ~allow_oe) == 8'h00) else $error("line driven without enable");
    oe_driven_a: assert property ($stable(trig_reg) [*3] ##0
        (trig_reg.line_drive && trig_reg.line_enable) |-> bp_trig_oe[trig_reg.line_select])
        else $error("selected output line not driven");
    out_follow_a: assert property (bp_trig_out ==
        (bp_trig_oe & {8{status.triggered}})) else $error("driven line differs from flag");
    level_hit_a: assert property (rd_valid |=>
        level_trigger_per_channel == $past(hit_exp)) else $error("level compare wrong");
    start_pre_a: assert property (acq_start && !acq_abort |=>
        status.acquiring && !status.triggered) else $error("start did not enter pre phase");
    strobe_gap_a: assert property (!ext_tb_sel && status.sample_strobe |=>
        !status.sample_strobe) else $error("strobe faster than timebase");
    trig_hold_a: assert property (status.triggered && !acq_start && !acq_abort |=>
        status.triggered) else $error("trigger flag dropped");
    cover property (status.done);
    cover property (status.triggered && bp_trig_oe != 8'h00);
    cover property (|level_trigger_per_channel);
endmodule // atc_properties

bind atc_top atc_properties #(
    .CHANNELS(CHANNELS), .LEVEL_W(LEVEL_W), .COUNT_W(COUNT_W), .PERIOD_W(PERIOD_W)
) atc_properties_inst (
    .clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .acq_start,
    .acq_abort, .mem_full, .ext_tb_sel, .ext_tb_tick, .ext_trig_pin, .bp_trig_in,
    .bp_trig_out, .bp_trig_oe, .rd_valid, .rd_data, .level_trigger_per_channel, .status
);

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
`include "atc_params.svh"
module testbench;
    import atc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic acq_start = 1'b0, acq_abort = 1'b0, mem_full = 1'b0, ext_trig_pin = 1'b0;
    logic rd_valid = 1'b0, pulse_go = 1'b0, ext_tb_sel = 1'b0, ext_tb_tick = 1'b0;
    logic tick_on = 1'b0;
    logic [2:0] pulse_line = 3'h0;
    logic [5:0] reg_addr = 6'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [3:0][7:0] rd_data = '0;
    logic [7:0] bp_in, bp_out, bp_oe;
    logic [3:0] lvl_hit;
    atc_status_t status;
    int seed = 32'hcdbe651a;
    int error_cnt = 0, checks_done = 0, n_pre, n_all;
    logic [5:0] ofs [13] = '{6'h28, 6'h2a, 6'h2c, 6'h2e, 6'h30, 6'h32, 6'h34,
        6'h36, 6'h38, 6'h3a, 6'h3c, 6'h26, 6'h3e};
    logic [15:0] msk [13] = '{16'hff01, 16'hff01, 16'hff01, 16'hff01, 16'h00ff,
        16'hffff, 16'h003f, 16'hffff, 16'h003f, 16'hffff, 16'hffff, 16'h0000, 16'h0000};
    logic [15:0] val [13];

    atc_top atc_top_inst (
        .clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .acq_start,
        .acq_abort, .mem_full, .ext_tb_sel, .ext_tb_tick, .ext_trig_pin,
        .bp_trig_in(bp_in), .bp_trig_out(bp_out), .bp_trig_oe(bp_oe), .rd_valid,
        .rd_data, .level_trigger_per_channel(lvl_hit), .status);
    atc_peer atc_peer_inst (.clk, .pulse_go, .pulse_line, .dut_oe(bp_oe),
        .dut_out(bp_out), .line_level(bp_in));

    always #25 clk = ~clk;
    // External timebase ticks every other cycle while enabled
    always @(posedge clk) ext_tb_tick <= tick_on & ~ext_tb_tick;
    //////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic pulse(input logic [2:0] ln);
        @(posedge clk);
        pulse_go <= 1'b1;
        pulse_line <= ln;
        @(posedge clk);
        pulse_go <= 1'b0;
    endtask
    task automatic abort;
        @(posedge clk);
        acq_abort <= 1'b1;
        @(posedge clk);
        acq_abort <= 1'b0;
    endtask
    task automatic start_acq(input logic [15:0] trig, input logic [15:0] pre,
                             input logic [15:0] cnt);
        wr(`ATC_OFS_TRIG, trig);
        wr(`ATC_OFS_PRE_HI, 16'h0000);
        wr(`ATC_OFS_PRE_LO, pre);
        wr(`ATC_OFS_CNT_HI, 16'h0000);
        wr(`ATC_OFS_CNT_LO, cnt);
        @(posedge clk);
        acq_start <= 1'b1;
        @(posedge clk);
        acq_start <= 1'b0;
    endtask
    // Runs two cycles past done so a registered final strobe is still counted
    task automatic wait_done;
        int i, tail;
        n_pre = 0;
        n_all = 0;
        tail = 0;
        for (i = 0; i < 3000 && tail < 3; i++) begin
            @(posedge clk);
            #1;
            if (status.sample_strobe === 1'b1) n_all++;
            if (status.sample_strobe === 1'b1 && status.triggered !== 1'b1) n_pre++;
            if (status.done === 1'b1) tail++;
        end
        if (i == 3000) begin
            error_cnt++;
            $display("wrong value at %0t: acquisition never completed", $time);
            conclude;
        end
    endtask
    task automatic try_edge(input logic [15:0] trig, input logic [2:0] ln, input logic early);
        start_acq(trig, 16'h0000, 16'h0000);
        repeat (3) @(posedge clk);
        pulse(ln + 3'h1);
        repeat (6) @(posedge clk);
        #1 chk(status.triggered, 1'b0);
        pulse(ln);
        repeat (4) @(posedge clk);
        #1 chk(status.triggered, early);
        repeat (6) @(posedge clk);
        #1 chk(status.triggered, 1'b1);
        abort;
    endtask
    function automatic logic [3:0] exp_hit(input int c, input logic [7:0] lv,
                                           input logic s, input logic [7:0] d);
        logic h;
        h = s ? ($signed(d) < $signed(lv)) : ($signed(d) > $signed(lv));
        return 4'(h) << c;
    endfunction
    //////////////////////////////////////////////////////////////////////////
    initial begin
        int i, k;
        logic [15:0] t;
        logic [31:0] r;
        logic [7:0] lv;
        logic s, e, any;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 13; i++) begin
            val[i] = 16'($random(seed));
            wr(ofs[i], val[i]);
        end
        for (i = 0; i < 13; i++) rd_chk(ofs[i], val[i] & msk[i]);
        wr(`ATC_OFS_PER_HI, 16'h0000);
        wr(`ATC_OFS_PER_LO, 16'h0002);
        // Counts kept tiny, far below any memory limit
        for (k = 0; k < 4; k++) begin
            t = 16'($random(seed) & 3);
            i = t + 1 + ($random(seed) & 3);
            start_acq(16'h009b, t, 16'(i));
            wait_done;
            chk(16'(n_pre), t);
            chk(16'(n_all), 16'(i));
            chk(bp_oe, 16'h0008);
            chk(bp_out, 16'h0008);
        end
        // Outside timebase selected but silent: pre phase must stall
        @(posedge clk);
        ext_tb_sel <= 1'b1;
        start_acq(16'h0080, 16'h0001, 16'h0002);
        repeat (20) @(posedge clk);
        #1 chk(status.triggered, 1'b0);
        @(posedge clk);
        tick_on <= 1'b1;
        wait_done;
        chk(16'(n_all), 16'h0002);
        @(posedge clk);
        ext_tb_sel <= 1'b0;
        tick_on <= 1'b0;
        start_acq(16'h0080, 16'h0000, 16'h0000);
        repeat (60) @(posedge clk);
        #1 chk(status.acquiring, 1'b1);
        @(posedge clk);
        mem_full <= 1'b1;
        wait_done;
        chk(status.done, 1'b1);
        @(posedge clk);
        mem_full <= 1'b0;
        for (i = 0; i < 8; i++) begin
            e = 1'($random(seed));
            try_edge({7'h00, e, 8'h10} | 16'(i), 3'(i), ~e);
        end
        for (k = 0; k < 4; k++) begin
            try_edge(16'h0120 | 16'(k << 10), 3'(2 * k), 1'b0);
            start_acq(16'h00c0 | 16'(k << 10), 16'h0000, 16'h0000);
            repeat (6) @(posedge clk);
            #1 chk(bp_oe, 16'h0001 << (2 * k));
            chk(bp_out, 16'h0001 << (2 * k));
            abort;
        end
        start_acq(16'h0105, 16'h0000, 16'h0000);
        pulse(3'h5);
        repeat (12) @(posedge clk);
        #1 chk(status.triggered, 1'b0);
        abort;
        start_acq(16'h0300, 16'h0000, 16'h0000);
        repeat (4) @(posedge clk);
        #1 chk(status.triggered, 1'b0);
        @(posedge clk);
        ext_trig_pin <= 1'b1;
        repeat (5) @(posedge clk);
        #1 chk(status.triggered, 1'b1);
        abort;
        for (k = 0; k < 4; k++) begin
            lv = 8'($random(seed));
            s = 1'($random(seed));
            wr(6'h28 + 6'(2 * k), {lv, 7'h00, s});
            start_acq(16'h1000 << k, 16'h0000, 16'h0000);
            repeat (3) @(posedge clk);
            any = 1'b0;
            for (i = 0; i < 24; i++) begin
                r = $random(seed);
                if (i % 4 == 0) r[8 * k +: 8] = lv;
                @(posedge clk);
                rd_valid <= 1'b1;
                rd_data <= r;
                @(posedge clk);
                rd_valid <= 1'b0;
                #1 chk(lvl_hit, exp_hit(k, lv, s, r[8 * k +: 8]));
                any = any | (|exp_hit(k, lv, s, r[8 * k +: 8]));
            end
            chk(status.triggered, any);
            abort;
        end
        conclude;
    end
endmodule // testbench
